// >>> fcs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_asserts import fcs_pkg::*; #(
	parameter int P_STEP_0 = STEP_CYC_0,
	parameter int P_STEP_1 = STEP_CYC_1,
	parameter int P_STEP_2 = STEP_CYC_2,
	parameter int P_STEP_3 = STEP_CYC_3
) (
	input wire logic          clk_sys,
	input wire logic          rst,
	input wire fcs_host_req_t host_req,
	input wire logic          dden_n,
	input wire logic          var_motor_ctl,
	input wire logic          var_fast_step,
	input wire logic          index_n,
	input wire logic          step_pulse,
	input wire logic          step_direction,
	input wire logic          spindle_motor_output,
	input wire logic          interrupt_request,
	input wire logic          busy,
	input wire logic          xfer_start,
	input wire fcs_xfer_t     xfer_ctl
);
	logic        take, ftake, fall, first_r, idx_r, arm_r;
	logic [7:0]  cmd_r;
	logic [3:0]  ix_r, idle_r;
	logic [19:0] hi_r, dir_r, rr_r, gap;
	assign take = host_req.wr && host_req.addr == ADDR_CMD_STATUS && (!busy || host_req.wdata[7:4] == OP_FORCE);
	assign ftake = take && host_req.wdata[7:4] == OP_FORCE;
	assign fall = idx_r && !index_n;
	// rise to rise spacing: pulse, then the programmed gap
	assign gap = 20'(cmd_r[1] ? (cmd_r[0] ? P_STEP_3 : P_STEP_2) : (cmd_r[0] ? P_STEP_1 : P_STEP_0))
		+ (dden_n ? 20'ha2 : 20'h52);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hi_r <= '0;
			rr_r <= '0;
			dir_r <= '0;
		end else begin
			hi_r <= step_pulse ? hi_r + 20'h1 : 20'h0;
			rr_r <= $rose(step_pulse) ? 20'h1 : rr_r + 20'h1;
			dir_r <= $changed(step_direction) ? 20'h0 : dir_r + 20'h1;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_r <= '0;
			first_r <= 1'b0;
			idx_r <= 1'b1;
			arm_r <= 1'b0;
			ix_r <= '0;
			idle_r <= '0;
		end else begin
			idx_r <= index_n;
			cmd_r <= (take && !ftake) ? host_req.wdata : cmd_r;
			first_r <= (take && !ftake) | (first_r && !$rose(step_pulse));
			arm_r <= (take && !ftake && !host_req.wdata[BIT_SPINUP] && var_motor_ctl && !spindle_motor_output)
				| (arm_r && !$fell(busy));
			ix_r <= (take && !ftake) ? 4'h0 : ix_r + 4'(fall && ix_r != 4'hf);
			idle_r <= busy ? 4'h0 : idle_r + 4'(fall && idle_r != 4'hf);
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_start;
		$rose(step_pulse) || xfer_start;
	endsequence
	a_done_irq: assert property ($fell(busy) && !$past(ftake) |=> interrupt_request)
		else $error("no interrupt at completion");
	a_irq_clear: assert property ((take && !ftake || host_req.rd && host_req.addr == ADDR_CMD_STATUS)
		&& !busy && !$past(busy) && index_n |=> !interrupt_request)
		else $error("interrupt not cleared");
	a_pulse_len: assert property ($fell(step_pulse) |-> hi_r == (dden_n ? PULSE_SD_CYC : PULSE_DD_CYC) + 20'h1)
		else $error("step pulse width wrong");
	a_dir_setup: assert property ($rose(step_pulse) |-> dir_r >= DIR_SETUP_CYC)
		else $error("direction changed too late");
	a_step_rate: assert property ($rose(step_pulse) && !first_r && !var_fast_step |-> rr_r == gap)
		else $error("step spacing wrong");
	a_spin_on: assert property (take && !ftake && !host_req.wdata[BIT_SPINUP] && var_motor_ctl
		&& !spindle_motor_output |=> spindle_motor_output)
		else $error("motor not started");
	a_spin_wait: assert property (arm_r ##0 s_start |-> ix_r >= SPINUP_REVS)
		else $error("started before spin-up");
	a_motor_idle: assert property ($fell(spindle_motor_output) |-> !busy && idle_r == IDLE_REVS)
		else $error("motor dropped at wrong time");
	a_force_now: assert property (ftake && host_req.wdata[FI_IMMEDIATE] |-> ##[1:2] interrupt_request)
		else $error("no immediate interrupt");
	a_xfer_multi: assert property (xfer_start |-> xfer_ctl.multi == (cmd_r[BIT_MULTI] && !cmd_r[6]))
		else $error("multi flag wrong");
endmodule // fcs_asserts
bind fcs_top fcs_asserts #(.P_STEP_0(P_STEP_0), .P_STEP_1(P_STEP_1), .P_STEP_2(P_STEP_2), .P_STEP_3(P_STEP_3))
	fcs_asserts_i (.clk_sys, .rst, .host_req, .dden_n, .var_motor_ctl, .var_fast_step, .index_n, .step_pulse,
	.step_direction, .spindle_motor_output, .interrupt_request, .busy, .xfer_start, .xfer_ctl);
`default_nettype wire

// >>> fcs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_drive_model #(
	parameter int REV_CYC = 300
) (
	input  wire logic  clk_sys,
	input  wire logic  rst,
	input  wire logic  step_pulse,
	input  wire logic  step_direction,
	input  wire logic  id_search,
	input  wire logic  crc_bad,
	output logic       index_n,
	output logic       track_zero_input_n,
	output logic       id_valid,
	output logic [7:0] id_track,
	output logic       id_crc_ok
);
	logic [8:0] rev_r;
	logic [5:0] id_r;
	logic [7:0] pos_r;
	logic       sp_r;
	// index low at the end of a turn, so the pin idles high out of reset
	assign index_n = rev_r < 9'(REV_CYC - 3);
	assign track_zero_input_n = pos_r != 8'h0;
	// outside a hit the id lines show the inverse, never a stale match
	assign id_track = id_valid ? pos_r : ~pos_r;
	assign id_crc_ok = id_valid ? !crc_bad : crc_bad;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rev_r <= 9'h0;
			id_r <= 6'h0;
			pos_r <= 8'h0;
			sp_r <= 1'b0;
			id_valid <= 1'b0;
		end else begin
			rev_r <= rev_r == 9'(REV_CYC - 1) ? 9'h0 : rev_r + 9'h1;
			sp_r <= step_pulse;
			if (step_pulse && !sp_r) pos_r <= step_direction ? pos_r + 8'h1 : pos_r - 8'(pos_r != 8'h0);
			id_r <= id_search ? id_r + 6'h1 : 6'h0;
			id_valid <= id_search && id_r == 6'h27;
		end
	end
endmodule // fcs_drive_model
`default_nettype wire

// >>> fcs_pkg.sv
package fcs_pkg;
	localparam int CLK_KHZ = 20000;
	localparam int CLK_MHZ = 20;
	localparam int STEP_MS_0 = 6;
	localparam int STEP_MS_1 = 12;
	localparam int STEP_MS_2 = 20;
	localparam int STEP_MS_3 = 30;
	localparam int STEP_FAST_MS_2 = 2;
	localparam int STEP_FAST_MS_3 = 3;
	localparam int SETTLE_MS = 30;
	localparam int SETTLE_FAST_MS = 15;
	localparam int PULSE_DD_US = 4;
	localparam int PULSE_SD_US = 8;
	localparam int DIR_SETUP_US = 24;
	localparam int STEP_CYC_0 = STEP_MS_0 * CLK_KHZ;
	localparam int STEP_CYC_1 = STEP_MS_1 * CLK_KHZ;
	localparam int STEP_CYC_2 = STEP_MS_2 * CLK_KHZ;
	localparam int STEP_CYC_3 = STEP_MS_3 * CLK_KHZ;
	localparam int STEP_FAST_CYC_2 = STEP_FAST_MS_2 * CLK_KHZ;
	localparam int STEP_FAST_CYC_3 = STEP_FAST_MS_3 * CLK_KHZ;
	localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
	localparam int SETTLE_FAST_CYC = SETTLE_FAST_MS * CLK_KHZ;
	localparam logic [19:0] PULSE_DD_CYC = 20'(PULSE_DD_US * CLK_MHZ);
	localparam logic [19:0] PULSE_SD_CYC = 20'(PULSE_SD_US * CLK_MHZ);
	localparam logic [19:0] DIR_SETUP_CYC = 20'(DIR_SETUP_US * CLK_MHZ);
	localparam logic [3:0] SPINUP_REVS = 4'h6;
	localparam logic [3:0] IDLE_REVS = 4'h9;
	localparam logic [3:0] VERIFY_REVS = 4'h5;
	localparam logic [7:0] RESTORE_MAX_STEPS = 8'hff;
	localparam logic [1:0] ADDR_CMD_STATUS = 2'h0;
	localparam logic [1:0] ADDR_TRACK = 2'h1;
	localparam logic [1:0] ADDR_SECTOR = 2'h2;
	localparam logic [1:0] ADDR_DATA = 2'h3;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] OP_RESTORE = 4'h0;
	localparam logic [3:0] OP_SEEK = 4'h1;
	localparam logic [3:0] OP_READ_ADDR = 4'hc;
	localparam logic [3:0] OP_FORCE = 4'hd;
	localparam logic [3:0] OP_WRITE_TRACK = 4'hf;
	localparam logic [2:0] GRP_STEP = 3'h1;
	localparam logic [2:0] GRP_STEP_IN = 3'h2;
	localparam logic [2:0] GRP_STEP_OUT = 3'h3;
	localparam logic [2:0] GRP_WRITE_SECTOR = 3'h5;
	localparam int BIT_UPDATE = 4;
	localparam int BIT_MULTI = 4;
	localparam int BIT_SPINUP = 3;
	localparam int BIT_SIDE = 3;
	localparam int BIT_VERIFY = 2;
	localparam int BIT_DELAY = 2;
	localparam int BIT_SIDE_CMP = 1;
	localparam int BIT_PRECOMP = 1;
	localparam int BIT_MARK = 0;
	localparam int FI_READY_RISE = 0;
	localparam int FI_READY_FALL = 1;
	localparam int FI_INDEX = 2;
	localparam int FI_IMMEDIATE = 3;
	localparam int ST_BUSY = 0;
	typedef enum logic [8:0] {
		FCS_IDLE    = 9'h001,
		FCS_SPINUP  = 9'h002,
		FCS_START   = 9'h004,
		FCS_DIRSET  = 9'h008,
		FCS_PULSE   = 9'h010,
		FCS_STEPGAP = 9'h020,
		FCS_SETTLE  = 9'h040,
		FCS_VERIFY  = 9'h080,
		FCS_XFER    = 9'h100
	} fcs_state_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} fcs_host_req_t;
	typedef struct packed {
		logic [3:0] op;
		logic       multi;
		logic       side_sel;
		logic       side_cmp_en;
		logic       precomp_en;
		logic       deleted_mark_select;
	} fcs_xfer_t;
endpackage

// >>> fcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_top import fcs_pkg::*; #(
	parameter int P_STEP_0      = STEP_CYC_0,
	parameter int P_STEP_1      = STEP_CYC_1,
	parameter int P_STEP_2      = STEP_CYC_2,
	parameter int P_STEP_3      = STEP_CYC_3,
	parameter int P_STEP_FAST_2 = STEP_FAST_CYC_2,
	parameter int P_STEP_FAST_3 = STEP_FAST_CYC_3,
	parameter int P_SETTLE      = SETTLE_CYC,
	parameter int P_SETTLE_FAST = SETTLE_FAST_CYC
) (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire fcs_host_req_t host_req,
	output logic [7:0]         host_rdata,
	input  wire logic          dden_n,
	input  wire logic          var_motor_ctl,
	input  wire logic          var_fast_step,
	input  wire logic          var_ready_irq,
	input  wire logic          index_n,
	input  wire logic          track_zero_input_n,
	input  wire logic          drive_ready,
	input  wire logic          id_valid,
	input  wire logic [7:0]    id_track,
	input  wire logic          id_crc_ok,
	input  wire logic          xfer_done,
	input  wire logic [7:0]    xfer_status,
	output logic               step_pulse,
	output logic               step_direction,
	output logic               spindle_motor_output,
	output logic               interrupt_request,
	output logic               busy,
	output logic               id_search,
	output logic               xfer_start,
	output logic               xfer_abort,
	output fcs_xfer_t          xfer_ctl,
	output logic [7:0]         track_out,
	output logic [7:0]         sector_out,
	output logic [7:0]         data_out
);
	fcs_state_t state_r;
	logic [7:0]  cmd_r;
	logic [7:0]  track_r;
	logic [7:0]  sector_r;
	logic [7:0]  data_r;
	logic [7:0]  xstat_r;
	logic [19:0] timer_r;
	logic [3:0]  rev_r;
	logic [3:0]  idle_rev_r;
	logic [7:0]  step_cnt_r;
	logic [3:0]  fi_cond_r;
	logic        busy_r;
	logic        dir_r;
	logic        step_r;
	logic        mo_r;
	logic        irq_r;
	logic        done_r;
	logic        crc_err_r;
	logic        seek_err_r;
	logic        spun_r;
	logic        to_xfer_r;
	logic        idx_prev_r;
	logic        rdy_prev_r;
	logic        xstart_r;
	logic        xabort_r;
	fcs_xfer_t   xctl_r;
	logic [7:0]  rdata_r;

	logic        cmd_wr;
	logic        is_force;
	logic        accept;
	logic        accept_cmd;
	logic        need_spinup;
	logic        idx_fall;
	logic        at_track0;
	logic        type1;
	logic [2:0]  grp;
	logic        verify_req;
	logic        update_req;
	logic        seek_done;
	logic [19:0] pulse_len;
	logic [19:0] rate_len;
	logic [19:0] settle_len;
	logic [7:0]  status_word;

	assign cmd_wr      = host_req.wr && (host_req.addr == ADDR_CMD_STATUS);
	assign is_force    = host_req.wdata[7:4] == OP_FORCE;
	assign accept      = cmd_wr && (is_force || !busy_r);
	assign accept_cmd  = accept && !is_force;
	// spin-up only when motor is still off; a running spindle skips it
	assign need_spinup = var_motor_ctl && !host_req.wdata[BIT_SPINUP] && !mo_r;
	assign idx_fall    = idx_prev_r && !index_n;
	assign at_track0   = !track_zero_input_n;
	assign type1       = !cmd_r[7];
	assign grp         = cmd_r[7:5];
	assign verify_req  = cmd_r[BIT_VERIFY];
	assign update_req  = (grp != 3'h0) && cmd_r[BIT_UPDATE];
	assign seek_done   = track_r == data_r;
	assign pulse_len   = dden_n ? PULSE_SD_CYC : PULSE_DD_CYC;
	assign settle_len  = var_fast_step ? 20'(P_SETTLE_FAST) : 20'(P_SETTLE);

	always_comb begin
		unique case (cmd_r[1:0])
			2'h0: rate_len = 20'(P_STEP_0);
			2'h1: rate_len = 20'(P_STEP_1);
			2'h2: rate_len = var_fast_step ? 20'(P_STEP_FAST_2) : 20'(P_STEP_2);
			2'h3: rate_len = var_fast_step ? 20'(P_STEP_FAST_3) : 20'(P_STEP_3);
		endcase
	end

	always_comb begin
		if (type1) begin
			status_word = {mo_r, 1'b0, spun_r, seek_err_r, crc_err_r, at_track0, !index_n, busy_r};
		end else begin
			status_word = {xstat_r[7:1], busy_r};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			idx_prev_r <= 1'b1;
			rdy_prev_r <= 1'b0;
		end else begin
			idx_prev_r <= index_n;
			rdy_prev_r <= drive_ready;
		end
	end

	// command sequencer, drive stepping and track register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r    <= FCS_IDLE;
			cmd_r      <= REG_RST;
			track_r    <= REG_RST;
			sector_r   <= REG_RST;
			data_r     <= REG_RST;
			xstat_r    <= REG_RST;
			timer_r    <= 20'h00000;
			rev_r      <= 4'h0;
			step_cnt_r <= 8'h00;
			busy_r     <= 1'b0;
			dir_r      <= 1'b0;
			step_r     <= 1'b0;
			done_r     <= 1'b0;
			crc_err_r  <= 1'b0;
			seek_err_r <= 1'b0;
			spun_r     <= 1'b0;
			to_xfer_r  <= 1'b0;
			xstart_r   <= 1'b0;
			xabort_r   <= 1'b0;
			xctl_r     <= '0;
		end else begin
			done_r   <= 1'b0;
			xstart_r <= 1'b0;
			xabort_r <= 1'b0;
			if (timer_r != 20'h00000) begin
				timer_r <= timer_r - 20'h00001;
			end
			if (host_req.wr && host_req.addr == ADDR_TRACK) begin
				track_r <= host_req.wdata;
			end
			if (host_req.wr && host_req.addr == ADDR_SECTOR) begin
				sector_r <= host_req.wdata;
			end
			if (host_req.wr && host_req.addr == ADDR_DATA) begin
				data_r <= host_req.wdata;
			end
			if (accept && is_force) begin
				cmd_r <= host_req.wdata;
				if (busy_r) begin
					state_r  <= FCS_IDLE;
					busy_r   <= 1'b0;
					step_r   <= 1'b0;
					xabort_r <= state_r == FCS_XFER;
				end
			end else if (accept_cmd) begin
				cmd_r      <= host_req.wdata;
				busy_r     <= 1'b1;
				crc_err_r  <= 1'b0;
				seek_err_r <= 1'b0;
				spun_r     <= 1'b0;
				rev_r      <= 4'h0;
				step_cnt_r <= 8'h00;
				state_r    <= need_spinup ? FCS_SPINUP : FCS_START;
			end else begin
				unique case (state_r)
					FCS_IDLE: begin
					end
					FCS_SPINUP: begin
						if (idx_fall) begin
							rev_r <= rev_r + 4'h1;
							if (rev_r == SPINUP_REVS - 4'h1) begin
								spun_r  <= 1'b1;
								state_r <= FCS_START;
							end
						end
					end
					FCS_START: begin
						timer_r <= DIR_SETUP_CYC;
						if (type1) begin
							if (cmd_r[7:4] == OP_RESTORE) begin
								dir_r <= 1'b0;
								if (at_track0) begin
									track_r <= REG_RST;
									if (verify_req) begin
										timer_r   <= settle_len;
										to_xfer_r <= 1'b0;
										state_r   <= FCS_SETTLE;
									end else begin
										busy_r  <= 1'b0;
										done_r  <= 1'b1;
										state_r <= FCS_IDLE;
									end
								end else begin
									state_r <= FCS_DIRSET;
								end
							end else if (cmd_r[7:4] == OP_SEEK) begin
								dir_r <= data_r > track_r;
								if (seek_done) begin
									if (verify_req) begin
										timer_r   <= settle_len;
										to_xfer_r <= 1'b0;
										state_r   <= FCS_SETTLE;
									end else begin
										busy_r  <= 1'b0;
										done_r  <= 1'b1;
										state_r <= FCS_IDLE;
									end
								end else begin
									state_r <= FCS_DIRSET;
								end
							end else begin
								// plain step keeps the previous direction
								if (grp == GRP_STEP_IN) begin
									dir_r <= 1'b1;
								end else if (grp == GRP_STEP_OUT) begin
									dir_r <= 1'b0;
								end
								state_r <= FCS_DIRSET;
							end
						end else if (cmd_r[BIT_DELAY]) begin
							timer_r   <= settle_len;
							to_xfer_r <= 1'b1;
							state_r   <= FCS_SETTLE;
						end else begin
							xstart_r <= 1'b1;
							state_r  <= FCS_XFER;
						end
					end
					FCS_DIRSET, FCS_STEPGAP: begin
						if (timer_r == 20'h00000) begin
							if (state_r == FCS_STEPGAP && type1 && cmd_r[7:4] == OP_RESTORE &&
								(at_track0 || step_cnt_r == RESTORE_MAX_STEPS)) begin
								if (at_track0) begin
									track_r <= REG_RST;
								end else begin
									seek_err_r <= verify_req;
								end
								if (at_track0 && verify_req) begin
									timer_r   <= settle_len;
									to_xfer_r <= 1'b0;
									state_r   <= FCS_SETTLE;
								end else begin
									busy_r  <= 1'b0;
									done_r  <= 1'b1;
									state_r <= FCS_IDLE;
								end
							end else if (state_r == FCS_STEPGAP &&
								(cmd_r[7:4] != OP_RESTORE && (cmd_r[7:4] != OP_SEEK || seek_done))) begin
								if (verify_req) begin
									timer_r   <= settle_len;
									to_xfer_r <= 1'b0;
									state_r   <= FCS_SETTLE;
								end else begin
									busy_r  <= 1'b0;
									done_r  <= 1'b1;
									state_r <= FCS_IDLE;
								end
							end else begin
								step_r     <= 1'b1;
								timer_r    <= pulse_len;
								step_cnt_r <= step_cnt_r + 8'h01;
								if (cmd_r[7:4] == OP_SEEK || update_req) begin
									track_r <= dir_r ? track_r + 8'h01 : track_r - 8'h01;
								end
								state_r <= FCS_PULSE;
							end
						end
					end
					FCS_PULSE: begin
						if (timer_r == 20'h00000) begin
							step_r  <= 1'b0;
							timer_r <= rate_len;
							state_r <= FCS_STEPGAP;
						end
					end
					FCS_SETTLE: begin
						if (timer_r == 20'h00000) begin
							rev_r <= 4'h0;
							if (to_xfer_r) begin
								xstart_r <= 1'b1;
								state_r  <= FCS_XFER;
							end else begin
								state_r <= FCS_VERIFY;
							end
						end
					end
					FCS_VERIFY: begin
						// a good ID in the same cycle as the limit still passes
						if (id_valid && id_track == track_r && id_crc_ok) begin
							busy_r  <= 1'b0;
							done_r  <= 1'b1;
							state_r <= FCS_IDLE;
						end else begin
							if (id_valid && id_track == track_r) begin
								crc_err_r <= 1'b1;
							end
							if (idx_fall) begin
								rev_r <= rev_r + 4'h1;
								if (rev_r == VERIFY_REVS - 4'h1) begin
									seek_err_r <= 1'b1;
									busy_r     <= 1'b0;
									done_r     <= 1'b1;
									state_r    <= FCS_IDLE;
								end
							end
						end
					end
					FCS_XFER: begin
						if (xfer_done) begin
							xstat_r <= xfer_status;
							busy_r  <= 1'b0;
							done_r  <= 1'b1;
							state_r <= FCS_IDLE;
						end
					end
				endcase
			end
			if (xstart_r == 1'b0 && state_r == FCS_START) begin
				xctl_r.op                  <= cmd_r[7:4];
				xctl_r.multi               <= !cmd_r[6] && cmd_r[BIT_MULTI];
				xctl_r.side_sel            <= cmd_r[BIT_SIDE];
				xctl_r.side_cmp_en         <= cmd_r[BIT_SIDE_CMP] && !cmd_r[6];
				xctl_r.precomp_en          <= (grp == GRP_WRITE_SECTOR || cmd_r[7:4] == OP_WRITE_TRACK) &&
					!cmd_r[BIT_PRECOMP];
				xctl_r.deleted_mark_select <= (grp == GRP_WRITE_SECTOR) && cmd_r[BIT_MARK];
			end
		end
	end

	// spindle motor: raised for spin-up, dropped after idle revolutions
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mo_r       <= 1'b0;
			idle_rev_r <= 4'h0;
		end else begin
			if (accept_cmd && need_spinup) begin
				mo_r <= 1'b1;
			end else if (!busy_r && mo_r && idx_fall && idle_rev_r == IDLE_REVS - 4'h1) begin
				mo_r <= 1'b0;
			end
			if (busy_r || accept_cmd || !mo_r) begin
				idle_rev_r <= 4'h0;
			end else if (idx_fall) begin
				idle_rev_r <= idle_rev_r + 4'h1;
			end
		end
	end

	// interrupt request; a set in the clearing cycle wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_r     <= 1'b0;
			fi_cond_r <= 4'h0;
		end else begin
			if (accept) begin
				fi_cond_r <= is_force ? host_req.wdata[3:0] : 4'h0;
			end
			if (done_r ||
				(accept && is_force && host_req.wdata[FI_IMMEDIATE]) ||
				(fi_cond_r[FI_INDEX] && idx_fall) ||
				(var_ready_irq && fi_cond_r[FI_READY_RISE] && drive_ready && !rdy_prev_r) ||
				(var_ready_irq && fi_cond_r[FI_READY_FALL] && !drive_ready && rdy_prev_r)) begin
				irq_r <= 1'b1;
			end else if (cmd_wr || (host_req.rd && host_req.addr == ADDR_CMD_STATUS)) begin
				irq_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= REG_RST;
		end else if (host_req.rd) begin
			unique case (host_req.addr)
				ADDR_CMD_STATUS: rdata_r <= status_word;
				ADDR_TRACK:      rdata_r <= track_r;
				ADDR_SECTOR:     rdata_r <= sector_r;
				ADDR_DATA:       rdata_r <= data_r;
			endcase
		end
	end

	assign host_rdata           = rdata_r;
	assign step_pulse           = step_r;
	assign step_direction       = dir_r;
	assign spindle_motor_output = mo_r;
	assign interrupt_request    = irq_r;
	assign busy                 = busy_r;
	assign id_search            = state_r == FCS_VERIFY;
	assign xfer_start           = xstart_r;
	assign xfer_abort           = xabort_r;
	assign xfer_ctl             = xctl_r;
	assign track_out            = track_r;
	assign sector_out           = sector_r;
	assign data_out             = data_r;
endmodule // fcs_top
`default_nettype wire

// >>> fcs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_top_test import fcs_pkg::*; ;
	logic          clk_sys, rst, dden_n, var_motor_ctl, crc_bad, xfer_done, step_pulse, step_direction;
	logic          spindle_motor_output, interrupt_request, busy, xfer_start, index_n, track_zero_input_n;
	logic          id_valid, id_crc_ok, id_search, var_fast_step, var_ready_irq, drive_ready, xfer_abort;
	logic [7:0]    id_track, host_rdata, track_out, c, xfer_status, data_out;
	fcs_host_req_t host_req;
	fcs_xfer_t     xfer_ctl;
	int            failures, n_tests, n;
	logic [7:0]    sc [4] = '{8'h58, 8'h28, 8'h38, 8'h78};
	logic [7:0]    st [4] = '{8'h01, 8'h01, 8'h02, 8'h01};
	logic [3:0]    sd = 4'h7;
	logic [7:0]    xc [3] = '{8'h94, 8'ha3, 8'hb0};
	fcs_top #(.P_STEP_0(60), .P_STEP_1(80), .P_STEP_2(100), .P_STEP_3(120), .P_SETTLE(100)) fcs_top_i (
		.clk_sys, .rst, .host_req, .host_rdata, .dden_n, .var_motor_ctl, .var_fast_step,
		.var_ready_irq, .index_n, .track_zero_input_n, .drive_ready, .id_valid, .id_track,
		.id_crc_ok, .xfer_done, .xfer_status, .step_pulse, .step_direction, .spindle_motor_output,
		.interrupt_request, .busy, .id_search, .xfer_start, .xfer_abort, .xfer_ctl, .track_out,
		.sector_out(), .data_out);
	fcs_drive_model fcs_drive_model_i (.clk_sys, .rst, .step_pulse, .step_direction, .id_search, .crc_bad,
		.index_n, .track_zero_input_n, .id_valid, .id_track, .id_crc_ok);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		host_req = '{1'b1, 1'b0, a, d};
		tick(1);
		host_req.wr = 1'b0;
	endtask
	task rd(input logic [7:0] exp, input logic [7:0] m);
		host_req = '{1'b0, 1'b1, ADDR_CMD_STATUS, 8'h00};
		tick(1);
		host_req.rd = 1'b0;
		chk(host_rdata & m, exp);
		// idle edge so a following request never reassigns the strobe in this step
		tick(1);
	endtask
	task wt(input int lim);
		int k;
		k = 0;
		while (busy === 1'b1 && k < lim) begin
			tick(1);
			k++;
		end
		chk(8'(k < lim), 8'h01);
		tick(1);
		chk(interrupt_request, 8'h01);
	endtask
	task run(input logic [7:0] cmd, input int lim);
		wr(ADDR_CMD_STATUS, cmd);
		chk(busy, 8'h01);
		wt(lim);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// whole run is near 19k cycles; allow well over double
	initial begin
		#3000000;
		failures++;
		test_done;
	end
	initial begin
		host_req = '0;
		{rst, dden_n, var_motor_ctl, crc_bad, xfer_done, var_fast_step, var_ready_irq, drive_ready, xfer_status} = 16'h8100;
		failures = 0;
		n_tests = 0;
		tick(6);
		rst = 1'b0;
		run(8'h08, 50);
		rd(8'h04, 8'hfd);
		chk(interrupt_request, 8'h00);
		$display("restore at home done");
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_DATA, 8'(2 * r + 2));
			tick(1);
			chk(data_out, 8'(2 * r + 2));
			run(8'h10 | 8'(r), 3000);
			chk(track_out, 8'(2 * r + 2));
			chk(step_direction, 8'h01);
		end
		run(8'h0b, 5000);
		chk(track_out, 8'h00);
		chk(step_direction, 8'h00);
		$display("seek and restore done");
		for (int i = 0; i < 4; i++) begin
			dden_n = i == 3;
			var_fast_step = i == 1;
			run(sc[i], 3000);
			chk(track_out, st[i]);
			chk(step_direction, 8'(sd[i]));
		end
		dden_n = 1'b0;
		run(8'h08, 3000);
		$display("step commands done");
		wr(ADDR_DATA, 8'h03);
		tick(1);
		wr(ADDR_CMD_STATUS, 8'h18);
		tick(1);
		run(8'h78, 3000);
		chk(track_out, 8'h03);
		chk(step_direction, 8'h01);
		$display("busy refusal done");
		run(8'h5c, 3000);
		rd(8'h00, 8'hfd);
		crc_bad = 1'b1;
		run(8'h5c, 5000);
		rd(8'h18, 8'hfd);
		crc_bad = 1'b0;
		$display("verify done");
		var_motor_ctl = 1'b1;
		wr(ADDR_CMD_STATUS, 8'h50);
		chk(spindle_motor_output, 8'h01);
		wt(4000);
		rd(8'ha0, 8'hfd);
		run(8'h50, 1000);
		n = 0;
		while (spindle_motor_output === 1'b1 && n < 3200) begin
			tick(1);
			n++;
		end
		chk({spindle_motor_output, 7'(n > 2300)}, 8'h01);
		var_motor_ctl = 1'b0;
		$display("motor done");
		rd(8'h00, 8'h81);
		chk(interrupt_request, 8'h00);
		wr(ADDR_CMD_STATUS, 8'hd8);
		tick(1);
		chk(interrupt_request, 8'h01);
		rd(8'h00, 8'h01);
		chk(interrupt_request, 8'h00);
		wr(ADDR_CMD_STATUS, 8'h0b);
		tick(10);
		wr(ADDR_CMD_STATUS, 8'hd0);
		tick(2);
		chk({busy, interrupt_request}, 8'h00);
		wr(ADDR_CMD_STATUS, 8'hd4);
		n = 0;
		while (interrupt_request !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		chk(interrupt_request, 8'h01);
		var_ready_irq = 1'b1;
		wr(ADDR_CMD_STATUS, 8'hd1);
		tick(1);
		rd(8'h00, 8'h01);
		drive_ready = 1'b0;
		tick(2);
		chk(interrupt_request, 8'h00);
		drive_ready = 1'b1;
		tick(2);
		chk(interrupt_request, 8'h01);
		var_ready_irq = 1'b0;
		$display("force done");
		for (int i = 0; i < 3; i++) begin
			c = xc[i];
			wr(ADDR_CMD_STATUS, c);
			n = 0;
			while (xfer_start !== 1'b1 && n < 300) begin
				tick(1);
				n++;
			end
			chk({1'b0, xfer_ctl.op, xfer_ctl.multi, xfer_ctl.precomp_en, xfer_ctl.deleted_mark_select}
				& (i == 0 ? 8'h7c : 8'h7f), {1'b0, c[7:4], c[4], !c[1], c[0]} & (i == 0 ? 8'h7c : 8'h7f));
			{xfer_done, xfer_status} = {1'b1, c};
			tick(1);
			xfer_done = 1'b0;
			wt(20);
			rd(c & 8'hfe, 8'hff);
		end
		wr(ADDR_CMD_STATUS, 8'h80);
		tick(4);
		wr(ADDR_CMD_STATUS, 8'hd0);
		chk({busy, xfer_abort}, 8'h01);
		$display("sector commands done");
		test_done;
	end
endmodule // fcs_top_test
`default_nettype wire
